/* verilog/swi_wait_state_inserter.sv */
// wait state inserter between external static memory accesses
// Operation
// - early read only same chip select, write-then-read
// - early read: zero write hold, zero read setup
// - cs-controlled write: zero cs hold, zero read setup
// - strobe-controlled write: wait on fed-back strobe
// - mode register write forces reload wait cycle
// - chip select change: idle cycle only
// - same chip select: reload even for others
// - slow clock change forces reload after transfer
// - one wait cycle between read and write
// - read-to-write cycle adds to other waits
// - float waits after read before conflicting access
// - per chip select float count 0..15
// - float waits never delay internal accesses
// - strobe-read float starts at strobe rise
// - cs-read float starts at chip select rise
// - optimization counts next setup against float
// - idle cycle drives all controls high
// - no optimization: float appended, hold covers it
// - write select picks data-driving strobe
`timescale 1ns/100ps
module swi_wait_state_inserter
    import swi_pkg::*;
#(
    parameter int NUM_CS = SWI_NUM_CS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // mode register writes from software
    input wire logic mode_wr_en,
    input wire logic [SWI_CS_W-1:0] mode_wr_cs,
    input wire logic mode_write_ctrl_select,
    input wire logic mode_read_ctrl_select,
    input wire logic [SWI_FLOAT_W-1:0] mode_float_cycle_count,
    input wire logic mode_float_optimize_en,
    // slow clock mode level from power management
    input wire logic slow_clock_mode,
    // access request from the system bus
    input wire logic acc_valid,
    input wire logic acc_internal,
    input wire logic acc_write,
    input wire logic [SWI_CS_W-1:0] acc_cs,
    input wire logic [SWI_TIME_W-1:0] acc_wstrobe_setup,
    input wire logic [SWI_TIME_W-1:0] acc_cs_write_setup,
    input wire logic [SWI_TIME_W-1:0] acc_rstrobe_setup,
    input wire logic [SWI_TIME_W-1:0] acc_cs_read_setup,
    input wire logic [SWI_TIME_W-1:0] acc_wstrobe_hold,
    input wire logic [SWI_TIME_W-1:0] acc_cs_write_hold,
    input wire logic [SWI_TIME_W-1:0] acc_rstrobe_hold,
    input wire logic [SWI_TIME_W-1:0] acc_cs_read_hold,
    output logic acc_ready,
    // waveform engine status
    input wire logic xfer_done,
    input wire logic write_strobe_phase,
    input wire logic cs_strobe_phase,
    // fed-back write strobe pin level
    input wire logic write_strobe_fb_n,
    // wait control and active configuration
    output logic force_inactive,
    output logic hold_extend,
    output logic cfg_load,
    output logic data_drive_en,
    output logic cur_write_ctrl_select,
    output logic cur_read_ctrl_select,
    output logic [SWI_FLOAT_W-1:0] cur_float_cycle_count,
    output logic float_busy
);

    // per chip select mode sets: shadow written by software, active in use
    logic [NUM_CS-1:0] sh_wsel_reg, act_wsel_reg;
    logic [NUM_CS-1:0] sh_rsel_reg, act_rsel_reg;
    logic [NUM_CS-1:0] sh_opt_reg, act_opt_reg;
    logic [SWI_FLOAT_W-1:0] sh_float_reg [NUM_CS];
    logic [SWI_FLOAT_W-1:0] act_float_reg [NUM_CS];

    swi_state_t state_reg, state_next;
    logic reload_pend_reg;
    logic slow_prev_reg;
    logic fb_meta_reg, fb_sync_reg;
    logic [SWI_WAIT_W-1:0] wait_cnt_reg;
    logic hold_ext_reg;
    logic cfg_load_reg;
    // previous external access
    logic prev_valid_reg, prev_write_reg;
    logic [SWI_CS_W-1:0] prev_cs_reg;
    logic prev_wsel_reg, prev_rsel_reg;
    logic prev_whold_zero_reg, prev_cshold_zero_reg;
    logic [SWI_FLOAT_W-1:0] prev_float_reg;
    logic [SWI_TIME_W-1:0] prev_rhold_reg;
    logic [SWI_TIME_W-1:0] float_rem_reg;

    // decode of the pending request
    wire logic is_idle = (state_reg == SWI_ST_IDLE);
    wire logic is_wait = (state_reg == SWI_ST_WAIT);
    wire logic ext_req = acc_valid && !acc_internal;
    wire logic cs_change = prev_valid_reg && (prev_cs_reg != acc_cs);
    wire logic same_cs = prev_valid_reg && (prev_cs_reg == acc_cs);
    wire logic wr_then_rd = same_cs && prev_write_reg && !acc_write;
    wire logic rd_then_wr = prev_valid_reg && !prev_write_reg && acc_write;
    wire logic next_rsel = act_rsel_reg[acc_cs];
    wire logic next_wsel = act_wsel_reg[acc_cs];
    wire logic [SWI_TIME_W-1:0] read_setup = next_rsel ? acc_rstrobe_setup : acc_cs_read_setup;
    wire logic [SWI_TIME_W-1:0] write_setup = next_wsel ? acc_wstrobe_setup : acc_cs_write_setup;
    wire logic [SWI_TIME_W-1:0] next_setup = acc_write ? write_setup : read_setup;
    wire logic ctrl_hold_zero = prev_wsel_reg ? prev_whold_zero_reg : prev_cshold_zero_reg;
    // early read conditions, each only for write-then-read on one chip select
    wire logic early_plain = wr_then_rd && ctrl_hold_zero && (read_setup == '0);
    wire logic early_cs = wr_then_rd && (prev_wsel_reg == SWI_SEL_CS)
                          && prev_cshold_zero_reg && (acc_cs_read_setup == '0);
    wire logic early_fb = wr_then_rd && (prev_wsel_reg == SWI_SEL_STROBE)
                          && prev_whold_zero_reg && !fb_sync_reg;
    wire logic early_read = early_plain || early_cs || early_fb;
    // reload is folded into the idle cycle when the chip select changes
    wire logic reload_due = reload_pend_reg && !cs_change;
    wire logic one_idle = cs_change || reload_due || early_read;
    wire logic [SWI_WAIT_W-1:0] fixed_wait = (one_idle ? SWI_IDLE_CYCLES : 2'h0)
                                             + (rd_then_wr ? SWI_RD2WR_CYCLES : 2'h0);
    // float applies after a read, to a write or to a read elsewhere
    wire logic float_applies = prev_valid_reg && !prev_write_reg && (acc_write || cs_change);
    wire logic prev_opt = act_opt_reg[prev_cs_reg];
    wire logic float_ok = !float_applies
                          || (prev_opt ? (float_rem_reg <= next_setup)
                                       : (float_rem_reg == '0));
    wire logic slow_edge = slow_clock_mode != slow_prev_reg;
    wire logic start_wait = is_idle && ext_req;
    wire logic grant_ext = is_wait && (wait_cnt_reg == '0) && float_ok;
    // float time left once the read hold is over
    wire logic [SWI_TIME_W-1:0] float_after_hold =
        swi_sat_sub({{(SWI_TIME_W-SWI_FLOAT_W){1'b0}}, prev_float_reg}, prev_rhold_reg);

    // internal accesses bypass every external wait
    assign acc_ready = (is_idle && acc_valid && acc_internal) || grant_ext;
    assign force_inactive = is_wait;
    assign hold_extend = is_wait && hold_ext_reg;
    assign cfg_load = cfg_load_reg;
    // data is driven while the selected strobe is in pulse or hold
    assign data_drive_en = (state_reg == SWI_ST_XFER) && prev_write_reg
                           && (prev_wsel_reg ? write_strobe_phase : cs_strobe_phase);
    assign cur_write_ctrl_select = prev_wsel_reg;
    assign cur_read_ctrl_select = prev_rsel_reg;
    assign cur_float_cycle_count = prev_float_reg;
    assign float_busy = (float_rem_reg != '0);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SWI_ST_IDLE: if (start_wait) state_next = SWI_ST_WAIT;
            SWI_ST_WAIT: if (grant_ext) state_next = SWI_ST_XFER;
            SWI_ST_XFER: if (xfer_done) state_next = SWI_ST_IDLE;
            default: state_next = SWI_ST_IDLE;
        endcase
    end

    // the feedback pin is asynchronous to the controller clock
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fb_meta_reg <= 1'b1;
            fb_sync_reg <= 1'b1;
        end else begin
            fb_meta_reg <= write_strobe_fb_n;
            fb_sync_reg <= fb_meta_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= SWI_ST_IDLE;
            slow_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            slow_prev_reg <= slow_clock_mode;
        end
    end

    // a new event wins over the clear taken in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reload_pend_reg <= 1'b0;
        end else if (mode_wr_en || slow_edge) begin
            reload_pend_reg <= 1'b1;
        end else if (start_wait) begin
            reload_pend_reg <= 1'b0;
        end
    end

    // software writes land in the shadow set only
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sh_wsel_reg <= {NUM_CS{SWI_WRITE_CTRL_RST}};
            sh_rsel_reg <= {NUM_CS{SWI_READ_CTRL_RST}};
            sh_opt_reg <= {NUM_CS{SWI_FLOAT_OPT_RST}};
            for (int i = 0; i < NUM_CS; i++) begin
                sh_float_reg[i] <= SWI_FLOAT_CNT_RST;
            end
        end else if (mode_wr_en) begin
            sh_wsel_reg[mode_wr_cs] <= mode_write_ctrl_select;
            sh_rsel_reg[mode_wr_cs] <= mode_read_ctrl_select;
            sh_opt_reg[mode_wr_cs] <= mode_float_optimize_en;
            sh_float_reg[mode_wr_cs] <= mode_float_cycle_count;
        end
    end

    // the active set changes only between transfers, never mid access
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            act_wsel_reg <= {NUM_CS{SWI_WRITE_CTRL_RST}};
            act_rsel_reg <= {NUM_CS{SWI_READ_CTRL_RST}};
            act_opt_reg <= {NUM_CS{SWI_FLOAT_OPT_RST}};
            for (int i = 0; i < NUM_CS; i++) begin
                act_float_reg[i] <= SWI_FLOAT_CNT_RST;
            end
            cfg_load_reg <= 1'b0;
        end else begin
            cfg_load_reg <= start_wait && reload_pend_reg;
            if (start_wait && reload_pend_reg) begin
                act_wsel_reg <= sh_wsel_reg;
                act_rsel_reg <= sh_rsel_reg;
                act_opt_reg <= sh_opt_reg;
                act_float_reg <= sh_float_reg;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wait_cnt_reg <= '0;
            hold_ext_reg <= 1'b0;
        end else if (start_wait) begin
            wait_cnt_reg <= fixed_wait;
            hold_ext_reg <= early_fb;
        end else if (is_wait && (wait_cnt_reg != '0)) begin
            wait_cnt_reg <= wait_cnt_reg - 2'h1;
        end
    end

    // record the granted access for the next decision
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prev_valid_reg <= 1'b0;
            prev_write_reg <= 1'b0;
            prev_cs_reg <= '0;
            prev_wsel_reg <= SWI_WRITE_CTRL_RST;
            prev_rsel_reg <= SWI_READ_CTRL_RST;
            prev_whold_zero_reg <= 1'b0;
            prev_cshold_zero_reg <= 1'b0;
            prev_float_reg <= SWI_FLOAT_CNT_RST;
            prev_rhold_reg <= '0;
        end else if (grant_ext) begin
            prev_valid_reg <= 1'b1;
            prev_write_reg <= acc_write;
            prev_cs_reg <= acc_cs;
            prev_wsel_reg <= next_wsel;
            prev_rsel_reg <= next_rsel;
            prev_whold_zero_reg <= (acc_wstrobe_hold == '0);
            prev_cshold_zero_reg <= (acc_cs_write_hold == '0);
            prev_float_reg <= act_float_reg[acc_cs];
            prev_rhold_reg <= next_rsel ? acc_rstrobe_hold : acc_cs_read_hold;
        end
    end

    // float period left, counted from the end of the read
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            float_rem_reg <= '0;
        end else if ((state_reg == SWI_ST_XFER) && xfer_done && !prev_write_reg) begin
            float_rem_reg <= float_after_hold;
        end else if (float_rem_reg != '0) begin
            float_rem_reg <= float_rem_reg - 8'h01;
        end
    end

    // cycles spent in the wait state, for the checks below
    logic [3:0] wait_len_reg;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wait_len_reg <= '0;
        end else if (start_wait) begin
            wait_len_reg <= '0;
        end else if (is_wait && (wait_len_reg != 4'hF)) begin
            wait_len_reg <= wait_len_reg + 4'h1;
        end
    end

    sequence s_wait_two;
        force_inactive [*2];
    endsequence

    property p_internal_now;
        @(posedge clk_sys) disable iff (!rst_n)
        is_idle && acc_valid && acc_internal |-> acc_ready;
    endproperty
    a_internal_now: assert property (p_internal_now) else $error("internal access delayed");

    property p_cs_change_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        start_wait && cs_change && !rd_then_wr && !float_applies |=> force_inactive ##1 acc_ready;
    endproperty
    a_cs_change_idle: assert property (p_cs_change_idle) else $error("chip select idle not one cycle");

    property p_rd2wr_extra;
        @(posedge clk_sys) disable iff (!rst_n)
        start_wait && cs_change && rd_then_wr |=> s_wait_two;
    endproperty
    a_rd2wr_extra: assert property (p_rd2wr_extra) else $error("read-to-write wait merged");

    property p_rd2wr_gap;
        @(posedge clk_sys) disable iff (!rst_n)
        start_wait && rd_then_wr |=> !acc_ready;
    endproperty
    a_rd2wr_gap: assert property (p_rd2wr_gap) else $error("no read-to-write wait");

    property p_reload_same_cs;
        @(posedge clk_sys) disable iff (!rst_n)
        start_wait && reload_pend_reg && same_cs |=> cfg_load && force_inactive && !acc_ready;
    endproperty
    a_reload_same_cs: assert property (p_reload_same_cs) else $error("reload wait missing");

    property p_mode_sets_reload;
        @(posedge clk_sys) disable iff (!rst_n)
        mode_wr_en |=> reload_pend_reg;
    endproperty
    a_mode_sets_reload: assert property (p_mode_sets_reload) else $error("mode write lost");

    property p_slow_reload;
        @(posedge clk_sys) disable iff (!rst_n)
        $changed(slow_clock_mode) |=> reload_pend_reg;
    endproperty
    a_slow_reload: assert property (p_slow_reload) else $error("slow clock change lost");

    property p_early_plain;
        @(posedge clk_sys) disable iff (!rst_n)
        start_wait && early_plain && !rd_then_wr |=> force_inactive ##1 (acc_ready || !float_ok);
    endproperty
    a_early_plain: assert property (p_early_plain) else $error("early read wait wrong");

    property p_early_fb_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        start_wait && early_fb |=> hold_extend;
    endproperty
    a_early_fb_hold: assert property (p_early_fb_hold) else $error("hold not extended");

    property p_no_early_other_cs;
        @(posedge clk_sys) disable iff (!rst_n)
        start_wait && cs_change && !float_applies |=> ##1 acc_ready;
    endproperty
    a_no_early_other_cs: assert property (p_no_early_other_cs) else $error("extra wait on cs change");

    property p_float_nonopt;
        @(posedge clk_sys) disable iff (!rst_n)
        grant_ext && float_applies && !prev_opt |-> float_rem_reg == '0;
    endproperty
    a_float_nonopt: assert property (p_float_nonopt) else $error("access inside float period");

    property p_float_opt;
        @(posedge clk_sys) disable iff (!rst_n)
        grant_ext && float_applies && prev_opt |-> float_rem_reg <= next_setup;
    endproperty
    a_float_opt: assert property (p_float_opt) else $error("setup shorter than float left");

    property p_grant_after_fixed;
        @(posedge clk_sys) disable iff (!rst_n)
        grant_ext |-> (wait_len_reg >= {3'h0, cs_change} + {3'h0, rd_then_wr}) && $past(is_wait || start_wait);
    endproperty
    a_grant_after_fixed: assert property (p_grant_after_fixed) else $error("strobes before waits done");

endmodule

/* include/swi_pkg.sv */
// shared constants and types for the static memory wait state inserter
package swi_pkg;

    // chip selects and field widths
    localparam int SWI_NUM_CS = 6;
    localparam int SWI_CS_W = 3;
    localparam int SWI_FLOAT_W = 4;
    localparam int SWI_TIME_W = 8;
    localparam int SWI_WAIT_W = 2;

    // mode field reset values
    localparam logic SWI_WRITE_CTRL_RST = 1'h1;
    localparam logic SWI_READ_CTRL_RST = 1'h1;
    localparam logic [3:0] SWI_FLOAT_CNT_RST = 4'h0;
    localparam logic SWI_FLOAT_OPT_RST = 1'h0;

    // strobe select encodings of the mode bits
    localparam logic SWI_SEL_STROBE = 1'h1;
    localparam logic SWI_SEL_CS = 1'h0;

    // wait cycle figures, in controller clock cycles
    localparam logic [1:0] SWI_IDLE_CYCLES = 2'h1;
    localparam logic [1:0] SWI_RD2WR_CYCLES = 2'h1;

    typedef enum logic [1:0] {
        SWI_ST_IDLE,
        SWI_ST_WAIT,
        SWI_ST_XFER
    } swi_state_t;

    // saturating difference, used for float remaining after the read hold
    function automatic logic [SWI_TIME_W-1:0] swi_sat_sub(
        input logic [SWI_TIME_W-1:0] a,
        input logic [SWI_TIME_W-1:0] b
    );
        swi_sat_sub = (a > b) ? (a - b) : {SWI_TIME_W{1'b0}};
    endfunction

endpackage

/* sim/swi_mem_model.sv */
// behavioural far side: waveform engine and fed-back write strobe pin
`timescale 1ns/100ps
module swi_mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // grant seen at the inserter
    input wire logic acc_valid,
    input wire logic acc_ready,
    input wire logic acc_internal,
    input wire logic acc_write,
    // pin load makes the strobe release late
    input wire logic slow_release,
    // engine status back to the inserter
    output logic xfer_done,
    output logic write_strobe_phase,
    output logic cs_strobe_phase,
    output logic write_strobe_fb_n
);
    logic [2:0] step_reg;
    logic [2:0] lag_reg;
    logic wr_reg;
    // on-chip grants never start an external transfer
    wire start = acc_valid && acc_ready && !acc_internal;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            step_reg <= 3'h0;
            lag_reg <= 3'h0;
            wr_reg <= 1'b0;
        end else begin
            if (start) begin
                step_reg <= 3'h1;
                wr_reg <= acc_write;
            end else if (step_reg != 3'h0) begin
                step_reg <= (step_reg == 3'h4) ? 3'h0 : step_reg + 3'h1;
            end
            lag_reg <= write_strobe_phase ? 3'h6 : ((lag_reg != 3'h0) ? lag_reg - 3'h1 : 3'h0);
        end
    end
    // chip select spans steps 1..3, write strobe only 2..3, hold ends at step 4
    assign cs_strobe_phase = (step_reg != 3'h0) && (step_reg != 3'h4);
    assign write_strobe_phase = wr_reg && (step_reg == 3'h2 || step_reg == 3'h3);
    assign xfer_done = (step_reg == 3'h4);
    assign write_strobe_fb_n = !(write_strobe_phase || (slow_release && lag_reg != 3'h0));
endmodule

/* sim/static_mem_wait_state_inserter_tb_top.sv */
// self-checking bench for the wait state inserter
`timescale 1ns/100ps
module static_mem_wait_state_inserter_tb_top;
    import swi_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
    logic clk_sys = 0, rst_n = 0, mode_wr_en = 0, mode_write_ctrl_select = 1, mode_read_ctrl_select = 1;
    logic [2:0] mode_wr_cs = 3'h0, acc_cs = 3'h0;
    logic [3:0] mode_float_cycle_count = 4'h0;
    logic mode_float_optimize_en = 0, slow_clock_mode = 0, acc_valid = 0, acc_internal = 0, acc_write = 0;
    logic [7:0] su = 8'h1, hs = 8'h1, hc = 8'h1;
    logic slow_release = 0, load_seen, hx_seen;
    logic acc_ready, xfer_done, write_strobe_phase, cs_strobe_phase, write_strobe_fb_n, force_inactive;
    logic hold_extend, cfg_load, data_drive_en, cur_write_ctrl_select, cur_read_ctrl_select, float_busy;
    logic [3:0] cur_float_cycle_count;
    int num_errors = 0, comparisons = 0;
    always #50 clk_sys = ~clk_sys;
    swi_wait_state_inserter dut_u (.clk_sys, .rst_n, .mode_wr_en, .mode_wr_cs, .mode_write_ctrl_select,
        .mode_read_ctrl_select, .mode_float_cycle_count, .mode_float_optimize_en, .slow_clock_mode,
        .acc_valid, .acc_internal, .acc_write, .acc_cs, .acc_wstrobe_setup(su), .acc_cs_write_setup(su),
        .acc_rstrobe_setup(su), .acc_cs_read_setup(su), .acc_wstrobe_hold(hs), .acc_cs_write_hold(hc),
        .acc_rstrobe_hold(hs), .acc_cs_read_hold(hc), .acc_ready, .xfer_done, .write_strobe_phase,
        .cs_strobe_phase, .write_strobe_fb_n, .force_inactive, .hold_extend, .cfg_load, .data_drive_en,
        .cur_write_ctrl_select, .cur_read_ctrl_select, .cur_float_cycle_count, .float_busy);
    swi_mem_model mem_u (.clk_sys, .rst_n, .acc_valid, .acc_ready, .acc_internal, .acc_write, .slow_release,
        .xfer_done, .write_strobe_phase, .cs_strobe_phase, .write_strobe_fb_n);
    task automatic summarize();
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // software mode register write, any write counts even if unchanged
    task automatic mwr(input int cs, input logic w, input logic r, input int f, input logic o);
        @(negedge clk_sys);
        mode_wr_en = 1;
        mode_wr_cs = cs[2:0];
        mode_write_ctrl_select = w;
        mode_read_ctrl_select = r;
        mode_float_cycle_count = f[3:0];
        mode_float_optimize_en = o;
        @(negedge clk_sys);
        mode_wr_en = 0;
    endtask
    // external access; grant latency in cycles must fall in lo..hi
    task automatic acc(input int cs, input logic wr, input int s, input int h1, input int h2, input int lo,
        input int hi, input logic ld, input logic dsel);
        int n;
        @(negedge clk_sys);
        n = 0;
        load_seen = 0;
        hx_seen = 0;
        acc_cs = cs[2:0];
        acc_write = wr;
        su = s[7:0];
        hs = h1[7:0];
        hc = h2[7:0];
        acc_valid = 1;
        do begin
            @(negedge clk_sys);
            n++;
            load_seen |= (cfg_load === 1'b1);
            hx_seen |= (hold_extend === 1'b1);
            `CHK(force_inactive, 1'b1)
        end while (acc_ready !== 1'b1 && n < 300);
        `CHK(n >= lo && n <= hi, 1'b1)
        if (ld)
            `CHK(load_seen, 1'b1)
        @(negedge clk_sys);
        acc_valid = 0;
        n = 0;
        while (xfer_done !== 1'b1 && n < 50) begin
            if (wr)
                `CHK(data_drive_en, dsel ? write_strobe_phase : cs_strobe_phase)
            @(negedge clk_sys);
            n++;
        end
    endtask
    initial begin
        #2000000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (6) @(negedge clk_sys);
        `CHK({cur_write_ctrl_select, cur_read_ctrl_select, cur_float_cycle_count, float_busy, cfg_load,
            force_inactive}, 9'h180)
        rst_n = 1;
        mwr(1, 0, 1, 0, 0);
        mwr(5, 1, 1, 10, 0);
        mwr(0, 1, 1, 10, 1);
        acc(0, 0, 9, 2, 2, 0, 255, 1, 1);
        acc(0, 1, 9, 0, 0, 2, 2, 0, 1);
        acc(5, 0, 1, 2, 9, 0, 255, 0, 1);
        // on-chip access while the float period is still running
        @(negedge clk_sys);
        acc_internal = 1;
        acc_valid = 1;
        #1;
        `CHK({acc_ready, float_busy}, 2'h3)
        @(negedge clk_sys);
        acc_valid = 0;
        acc_internal = 0;
        acc(4, 0, 1, 2, 2, 4, 11, 0, 1);
        mwr(5, 1, 0, 10, 0);
        acc(5, 0, 1, 9, 2, 0, 255, 1, 1);
        `CHK(cur_read_ctrl_select, SWI_SEL_CS)
        `CHK({cur_write_ctrl_select, cur_float_cycle_count}, 5'h1A)
        acc(4, 0, 1, 2, 2, 6, 11, 0, 1);
        acc(2, 1, 1, 2, 2, 3, 3, 0, 1);
        acc(2, 0, 1, 2, 2, 1, 1, 0, 1);
        acc(2, 0, 1, 2, 2, 1, 1, 0, 1);
        mwr(3, 1, 1, 0, 0);
        acc(2, 0, 1, 2, 2, 2, 2, 1, 1);
        mwr(3, 1, 1, 0, 0);
        acc(4, 0, 1, 2, 2, 2, 2, 0, 1);
        @(negedge clk_sys);
        slow_clock_mode = 1;
        acc(4, 0, 1, 2, 2, 2, 2, 0, 1);
        @(negedge clk_sys);
        slow_clock_mode = 0;
        acc(4, 0, 1, 2, 2, 2, 2, 0, 1);
        acc(1, 1, 1, 2, 0, 0, 255, 0, 0);
        acc(1, 0, 0, 2, 2, 2, 2, 0, 1);
        acc(1, 1, 1, 2, 0, 2, 2, 0, 0);
        acc(4, 0, 0, 2, 2, 2, 2, 0, 1);
        slow_release = 1;
        acc(2, 1, 1, 0, 2, 3, 3, 0, 1);
        acc(2, 0, 1, 2, 2, 2, 12, 0, 1);
        `CHK(hx_seen, 1'b1)
        slow_release = 0;
        acc(2, 1, 1, 0, 2, 2, 2, 0, 1);
        acc(2, 0, 0, 2, 2, 2, 4, 0, 1);
        summarize();
    end
endmodule
